// [include/acmp_pkg.sv]
package acmp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
    localparam logic [11:0] ADDR_INPUT_OFF = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h010;
    localparam logic [11:0] ADDR_PIN_STATUS = 12'h014;
    localparam logic [11:0] ADDR_IRQ_ACK = 12'h018;

    // ****************************************
    // Control/status field positions
    // ****************************************
    localparam int BIT_POWER_OFF = 7;
    localparam int BIT_REF_SELECT = 6;
    localparam int BIT_SYNC_OUT = 5;
    localparam int BIT_EVENT_FLAG = 4;
    localparam int BIT_IRQ_ENABLE = 3;
    localparam int BIT_CAPTURE_ROUTE = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_POS_OFF = 0;
    localparam int BIT_NEG_OFF = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] RST_INPUT_OFF = 2'h0;
    localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

    // ****************************************
    // Event modes
    // ****************************************
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALLING = 2'h2;
    localparam logic [1:0] MODE_RISING = 2'h3;

    // Interrupt-block event bits
    localparam int EV_CMP = 0;
    localparam int EV_PWR_CHANGE = 1;

endpackage : acmp_pkg

// [core/acmp_sync.sv]
`timescale 1ns/1ps
module acmp_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : acmp_sync

// [core/acmp_core.sv]
`timescale 1ns/1ps
// Functional notes
// - Raw result high when positive exceeds negative
// - Power-off bit removes comparator power anytime
// - Reference select picks bandgap or pin
// - Output synchronised, one to two cycles
// - Matching edge sets the event flag
// - Irq needs flag, local and global enable
// - Vector execution clears the event flag
// - Writing one clears flag, zero ignored
// - Mode 00 toggle, 10 fall, 11 rise
// - Route bit feeds timer capture front end
// - Route clear disconnects capture path entirely
// - Input-off bit forces pin read zero
module acmp_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_raw_result,
    output logic cmp_power_off,
    output logic reference_select,
    input wire logic cmp_positive_pin,
    input wire logic cmp_negative_pin,
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic cmp_irq,
    output logic capture_in,
    output logic [1:0] pin_read,
    output logic irq
);
    // ****************************************
    // Bus decode
    // ****************************************
    wire bus_access = psel && penable;
    wire wr_en = bus_access && pwrite && pstrb[0];
    wire hit_ctrl = paddr == acmp_pkg::ADDR_CTRL_STATUS;
    wire hit_off = paddr == acmp_pkg::ADDR_INPUT_OFF;
    wire hit_ists = paddr == acmp_pkg::ADDR_IRQ_STATUS;
    wire hit_ien = paddr == acmp_pkg::ADDR_IRQ_ENABLE;
    wire hit_iclr = paddr == acmp_pkg::ADDR_IRQ_CLEAR;
    wire hit_pin = paddr == acmp_pkg::ADDR_PIN_STATUS;
    wire hit_ack = paddr == acmp_pkg::ADDR_IRQ_ACK;
    wire mapped = hit_ctrl | hit_off | hit_ists | hit_ien | hit_iclr | hit_pin | hit_ack;
    wire wr_ctrl = wr_en && hit_ctrl;
    wire wr_off = wr_en && hit_off;
    wire wr_ien = wr_en && hit_ien;
    wire wr_iclr = wr_en && hit_iclr;

    assign pready = 1'b1;
    assign pslverr = bus_access && !mapped;

    // ****************************************
    // Control registers
    // ****************************************
    logic power_off_q;
    logic ref_sel_q;
    logic irq_en_q;
    logic route_q;
    logic [1:0] mode_q;
    logic [1:0] input_off_q;
    logic [1:0] int_en_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_off_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_POWER_OFF];
            ref_sel_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_REF_SELECT];
            irq_en_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_IRQ_ENABLE];
            route_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_CAPTURE_ROUTE];
            mode_q <= acmp_pkg::RST_CTRL[acmp_pkg::BIT_MODE_HI:acmp_pkg::BIT_MODE_LO];
        end else if (wr_ctrl) begin
            power_off_q <= pwdata[acmp_pkg::BIT_POWER_OFF];
            ref_sel_q <= pwdata[acmp_pkg::BIT_REF_SELECT];
            irq_en_q <= pwdata[acmp_pkg::BIT_IRQ_ENABLE];
            route_q <= pwdata[acmp_pkg::BIT_CAPTURE_ROUTE];
            mode_q <= pwdata[acmp_pkg::BIT_MODE_HI:acmp_pkg::BIT_MODE_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_off_q <= acmp_pkg::RST_INPUT_OFF;
            int_en_q <= acmp_pkg::RST_IRQ_ENABLE;
        end else begin
            if (wr_off) begin
                input_off_q <= pwdata[1:0];
            end
            if (wr_ien) begin
                int_en_q <= pwdata[1:0];
            end
        end
    end

    // Analog controls straight from register bits
    assign cmp_power_off = power_off_q;
    assign reference_select = ref_sel_q;

    // ****************************************
    // Output synchroniser and edge detection
    // ****************************************
    logic sync_out;
    logic sync_prev;
    logic cmp_sync_out;

    // A powered-off comparator reads low, so no stale level survives power-off
    acmp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_raw_result && !power_off_q),
        .sync_out(sync_out)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= sync_out;
        end
    end

    assign cmp_sync_out = sync_out;

    wire rise = sync_out && !sync_prev;
    wire fall = !sync_out && sync_prev;
    logic event_hit;

    always_comb begin
        unique case (mode_q)
            acmp_pkg::MODE_TOGGLE: event_hit = rise | fall;
            acmp_pkg::MODE_FALLING: event_hit = fall;
            acmp_pkg::MODE_RISING: event_hit = rise;
            acmp_pkg::MODE_RESERVED: event_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Event flag
    // ****************************************
    logic cmp_event_flag;
    wire flag_clr_sw = wr_ctrl && pwdata[acmp_pkg::BIT_EVENT_FLAG];
    wire ack_pulse = irq_vector_ack || (wr_en && hit_ack);
    wire flag_clr = flag_clr_sw || (ack_pulse && cmp_irq);
    wire next_flag = event_hit ? 1'b1 : (flag_clr ? 1'b0 : cmp_event_flag);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_event_flag <= 1'b0;
        end else begin
            cmp_event_flag <= next_flag;
        end
    end

    assign cmp_irq = cmp_event_flag && irq_en_q && global_irq_enable;

    // ****************************************
    // Capture routing and pin reads
    // ****************************************
    assign capture_in = route_q ? sync_out : 1'b0;

    logic [1:0] pin_sync1;
    logic [1:0] pin_sync2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync1 <= 2'h0;
            pin_sync2 <= 2'h0;
        end else begin
            pin_sync1 <= {cmp_negative_pin, cmp_positive_pin};
            pin_sync2 <= pin_sync1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            assign pin_read[gi] = pin_sync2[gi] && !input_off_q[gi];
        end
    endgenerate

    // ****************************************
    // Interrupt status block
    // ****************************************
    logic [1:0] int_status;
    logic [1:0] int_events;
    assign int_events[acmp_pkg::EV_CMP] = event_hit;
    assign int_events[acmp_pkg::EV_PWR_CHANGE] = wr_ctrl && (pwdata[acmp_pkg::BIT_POWER_OFF] != power_off_q);
    wire [1:0] int_clr = wr_iclr ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 2'h0;
        end else begin
            // Set wins over a simultaneous clear
            int_status <= int_events | (int_status & ~int_clr);
        end
    end

    assign irq = |(int_status & int_en_q);

    // ****************************************
    // Read data
    // ****************************************
    wire [7:0] ctrl_rd = {power_off_q, ref_sel_q, cmp_sync_out, cmp_event_flag, irq_en_q, route_q, mode_q};
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        if (hit_ctrl) begin
            rd_mux = {24'h0, ctrl_rd};
        end else if (hit_off) begin
            rd_mux = {30'h0, input_off_q};
        end else if (hit_ists) begin
            rd_mux = {30'h0, int_status};
        end else if (hit_ien) begin
            rd_mux = {30'h0, int_en_q};
        end else if (hit_pin) begin
            rd_mux = {30'h0, pin_read};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_rise_seen;
        !sync_prev && sync_out;
    endsequence

    sequence s_fall_seen;
        sync_prev && !sync_out;
    endsequence

    sequence s_local_off;
        wr_ctrl && !pwdata[acmp_pkg::BIT_IRQ_ENABLE];
    endsequence

    chk_flag_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_RISING) ##0 s_rise_seen |=> cmp_event_flag)
        else $error("rising edge did not set event flag");

    chk_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
        s_local_off |=> !cmp_irq)
        else $error("irq still raised after local enable cleared");

    chk_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clr_sw && !event_hit) |=> !cmp_event_flag)
        else $error("software clear failed");

    chk_vector_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_vector_ack && cmp_irq && !event_hit) |=> !cmp_event_flag)
        else $error("vector did not clear flag");

    chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmp_raw_result && !power_off_q) ##0 (cmp_raw_result && !power_off_q) [*2] |-> ##1 cmp_sync_out)
        else $error("sync latency exceeded two cycles");

    chk_route_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!route_q && cmp_raw_result && !power_off_q) [*3] |-> !capture_in)
        else $error("capture path driven while route off");

    chk_route_on: assert property (@(posedge pclk) disable iff (!presetn)
        (route_q && cmp_raw_result && !power_off_q) [*3] |-> capture_in)
        else $error("capture path not following output");

    chk_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
        wr_off |=> (pin_read & $past(pwdata[1:0])) == 2'h0)
        else $error("disabled pin reads nonzero");

    chk_reserved_mode: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_RESERVED && !flag_clr) |=> $stable(cmp_event_flag))
        else $error("reserved mode changed flag");

    chk_power_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> cmp_power_off == $past(pwdata[acmp_pkg::BIT_POWER_OFF]))
        else $error("power-off write not taken");

    chk_edge_once: assert property (@(posedge pclk) disable iff (!presetn)
        s_rise_seen |=> !rise)
        else $error("edge reported twice");

    chk_flag_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_FALLING) ##0 s_fall_seen |=> cmp_event_flag)
        else $error("falling edge did not set event flag");

    chk_flag_on_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_TOGGLE && (rise || fall)) |=> cmp_event_flag)
        else $error("toggle did not set event flag");

    chk_fall_ignores_rise: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_FALLING && rise && !cmp_event_flag) |=> !cmp_event_flag)
        else $error("rising edge set flag in falling mode");

    chk_rise_ignores_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == acmp_pkg::MODE_RISING && fall && !cmp_event_flag) |=> !cmp_event_flag)
        else $error("falling edge set flag in rising mode");

    chk_ref_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> reference_select == $past(pwdata[acmp_pkg::BIT_REF_SELECT]))
        else $error("reference select write not taken");

    chk_irq_all_on: assert property (@(posedge pclk) disable iff (!presetn)
        (event_hit && irq_en_q && !wr_ctrl) ##1 global_irq_enable |-> cmp_irq)
        else $error("irq missing with flag and both enables");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (event_hit && flag_clr) |=> cmp_event_flag)
        else $error("clear beat a simultaneous event");

    chk_sync_fall: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(cmp_raw_result && !power_off_q) ##0 (!(cmp_raw_result && !power_off_q)) [*2] |-> ##1 !cmp_sync_out)
        else $error("sync fall latency exceeded two cycles");

    chk_power_gates: assert property (@(posedge pclk) disable iff (!presetn)
        power_off_q [*3] |-> !cmp_sync_out)
        else $error("output high while comparator unpowered");

    chk_pin_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (!input_off_q[0] && cmp_positive_pin) [*3] |-> pin_read[0])
        else $error("enabled pin not read");

    chk_edge_once_fall: assert property (@(posedge pclk) disable iff (!presetn)
        s_fall_seen |=> !fall)
        else $error("falling edge reported twice");

    chk_ack_needs_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (ack_pulse && !cmp_irq && cmp_event_flag && !flag_clr_sw) |=> cmp_event_flag)
        else $error("vector cleared flag without request");

endmodule : acmp_core

// [test/acmp_analog_model.sv]
`timescale 1ns/1ps
// ****************************************
// Comparator front end in mV, timer capture front end
// ****************************************
module acmp_analog_model #(
    parameter logic [15:0] BANDGAP_MV = 16'h044c
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmp_power_off,
    input wire logic reference_select,
    input wire logic [15:0] pos_mv,
    input wire logic [15:0] neg_mv,
    input wire logic capture_in,
    input wire logic capture_irq_enable,
    output logic cmp_raw_result,
    output logic capture_irq
);
    logic [15:0] plus_mv;
    logic capture_prev;

    assign plus_mv = reference_select ? BANDGAP_MV : pos_mv;
    // Unpowered stage drives low so no stale result survives power-off
    assign cmp_raw_result = !cmp_power_off && (plus_mv > neg_mv);

    // Timer side: rising-edge select, sticky request raised only while its mask bit is set, held until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_prev <= 1'b0;
            capture_irq <= 1'b0;
        end else begin
            capture_prev <= capture_in;
            if (capture_irq_enable && capture_in && !capture_prev) begin
                capture_irq <= 1'b1;
            end
        end
    end
endmodule : acmp_analog_model

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb;
    logic cmp_raw_result, cmp_power_off, reference_select, cmp_positive_pin, cmp_negative_pin;
    logic global_irq_enable, irq_vector_ack, cmp_irq, capture_in, irq, capture_irq_enable, capture_irq;
    logic [1:0] pin_read;
    logic [15:0] pos_mv, neg_mv;
    int num_errors, samples_checked;

    acmp_core acmp_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_raw_result(cmp_raw_result), .cmp_power_off(cmp_power_off), .reference_select(reference_select),
        .cmp_positive_pin(cmp_positive_pin), .cmp_negative_pin(cmp_negative_pin),
        .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .cmp_irq(cmp_irq),
        .capture_in(capture_in), .pin_read(pin_read), .irq(irq));
    acmp_analog_model acmp_analog_model_inst (.cmp_power_off(cmp_power_off), .reference_select(reference_select),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw_result(cmp_raw_result), .pclk(pclk), .presetn(presetn),
        .capture_in(capture_in), .capture_irq_enable(capture_irq_enable), .capture_irq(capture_irq));

    always #4 pclk = ~pclk;

    // ****************************************
    // Bus and stimulus tasks
    // ****************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave asks; only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic set_in(input logic [15:0] p, input logic [15:0] n);
        @(posedge pclk);
        pos_mv <= p;
        neg_mv <= n;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask : set_in

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, cmp_positive_pin, cmp_negative_pin} = '0;
        {global_irq_enable, irq_vector_ack, capture_irq_enable, num_errors, samples_checked} = '0;
        pstrb = 4'hf;
        pos_mv = 16'h0100;
        neg_mv = 16'h0200;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK(rdata[7:0], acmp_pkg::RST_CTRL)
        apb(1'b0, acmp_pkg::ADDR_IRQ_ENABLE, 32'h0);
        `CHK(rdata[1:0], acmp_pkg::RST_IRQ_ENABLE)
        apb(1'b0, 12'h0fc, 32'h0);
        `CHK({pready, rerr, rdata}, 34'h300000000)
        $display("test reset done");

        set_in(16'h0600, 16'h0500);
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK(rdata[5], 1'b1)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h40);
        set_in(16'h0600, 16'h0500);
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK({reference_select, rdata[5]}, 2'h2)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        $display("test reference done");

        apb(1'b1, acmp_pkg::ADDR_IRQ_CLEAR, 32'h3);
        apb(1'b1, acmp_pkg::ADDR_IRQ_ENABLE, 32'h2);
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h80);
        set_in(16'h0600, 16'h0500);
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK({cmp_power_off, irq, rdata[5]}, 3'h6)
        apb(1'b1, acmp_pkg::ADDR_IRQ_ENABLE, 32'h0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, acmp_pkg::ADDR_IRQ_CLEAR, 32'h2);
        apb(1'b0, acmp_pkg::ADDR_IRQ_STATUS, 32'h0);
        `CHK(rdata[1:0], 2'h1)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        $display("test power done");

        // Local enable stays off while the mode changes, rise then fall checked each pass
        for (int m = 0; m < 4; m++) begin
            set_in(16'h0100, 16'h0200);
            apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h10 | m);
            set_in(16'h0300, 16'h0200);
            apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
            `CHK(rdata[4], 4'b1001 >> m & 1'b1)
            apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h10 | m);
            set_in(16'h0100, 16'h0200);
            apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
            `CHK(rdata[4], 4'b0101 >> m & 1'b1)
        end
        $display("test modes done");

        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h1b);
        set_in(16'h0300, 16'h0200);
        `CHK(cmp_irq, 1'b0)
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        @(negedge pclk);
        `CHK(cmp_irq, 1'b1)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h03);
        @(negedge pclk);
        `CHK(cmp_irq, 1'b0)
        apb(1'b1, acmp_pkg::ADDR_IRQ_ACK, 32'h0);
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h0b);
        @(negedge pclk);
        `CHK(cmp_irq, 1'b1)
        @(posedge pclk);
        irq_vector_ack <= 1'b1;
        @(posedge pclk);
        irq_vector_ack <= 1'b0;
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK({cmp_irq, rdata[4]}, 2'h0)
        set_in(16'h0100, 16'h0200);
        set_in(16'h0300, 16'h0200);
        `CHK(cmp_irq, 1'b1)
        apb(1'b1, acmp_pkg::ADDR_IRQ_ACK, 32'h0);
        apb(1'b0, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        `CHK({cmp_irq, rdata[4]}, 2'h0)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h03);
        global_irq_enable <= 1'b0;
        $display("test interrupt done");

        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h04);
        @(negedge pclk);
        `CHK(capture_in, 1'b1)
        set_in(16'h0100, 16'h0200);
        `CHK({capture_in, capture_irq}, 2'h0)
        @(posedge pclk);
        capture_irq_enable <= 1'b1;
        set_in(16'h0300, 16'h0200);
        `CHK({capture_in, capture_irq}, 2'h3)
        apb(1'b1, acmp_pkg::ADDR_CTRL_STATUS, 32'h0);
        @(negedge pclk);
        `CHK(capture_in, 1'b0)
        $display("test capture done");

        cmp_positive_pin <= 1'b1;
        cmp_negative_pin <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, acmp_pkg::ADDR_INPUT_OFF, 32'(k));
            repeat (3) @(posedge pclk);
            apb(1'b0, acmp_pkg::ADDR_PIN_STATUS, 32'h0);
            `CHK({pin_read, rdata[1:0]}, {2{2'(~k)}})
        end
        $display("test input off done");
        report_and_stop;
    end
endmodule : tb_top
